// ### src/ecm_host_mailbox.sv
// host mailbox: lpc i/o slave, config registers and mailbox flags
//
// Contract
// - cycle nibble 00 i/o, bit1 selects write
// - device drives 0110 per wait clock
// - device ends sync with 0000, no error
// - read byte follows sync as two nibbles
// - after read data drive 1111, then release
// - write gets two 0110 syncs, 0000, 1111
// - power-down then release needs no bus reset
// - power-down resets only link logic
// - decode only while activate bit d0 set
// - base from high nibble and low byte
// - base bits 0 and 2 forced zero
// - data port at base, command at base+4
// - both host ports fill one data byte
// - data write clears cmd bit, command sets it
// - host write sets input full, read clears
// - micro write sets output full, host clears
`timescale 1ns/100ps
module ecm_host_mailbox
   import ecm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic lpc_clk,
   input wire logic lreset_n,
   input wire logic lpcpd_n,
   input wire logic lframe_n,
   input wire logic [3:0] lad_in,
   output logic [3:0] lad_out,
   output logic lad_oe
);
   // ---------------- link domain ----------------
   logic lres_q1, lres_q2, pd_q1, pd_q2, ack_q1, ack_q2;
   logic [12:0] cfg_q1, cfg_q2;
   logic lk_rst;
   ecm_state_e st_r, st_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic wr_r, wr_nxt, cmd_r, cmd_nxt, req_r, req_nxt;
   logic [7:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
   logic [3:0] lad_nxt;
   logic oe_nxt, hit_data, hit_cmd;
   logic [11:0] base_s;
   // sys domain state read across
   logic [7:0] rsp_r;
   logic ack_r;
   logic act_r, act_nxt;
   logic [3:0] bhi_r, bhi_nxt;
   logic [7:0] blo_r, blo_nxt, inb_r, inb_nxt, outb_r, outb_nxt;

   always_ff @(posedge lpc_clk) begin
      lres_q1 <= lreset_n;
      lres_q2 <= lres_q1;
      pd_q1 <= lpcpd_n;
      pd_q2 <= pd_q1;
      ack_q1 <= ack_r;
      ack_q2 <= ack_q1;
      cfg_q1 <= {act_r, bhi_r, blo_r};
      cfg_q2 <= cfg_q1;
   end

   // power-down only resets this side; the flag side keeps its state
   assign lk_rst = !lres_q2 || !pd_q2;
   assign base_s = cfg_q2[11:0] & {4'hf, BASE_LO_MASK};
   // config is quasi-static, so a plain level sync is enough here
   assign hit_data = cfg_q2[12] && addr_r[15:12] == 4'h0
                     && addr_r[11:0] == base_s;
   assign hit_cmd = cfg_q2[12] && addr_r[15:12] == 4'h0
                    && addr_r[11:0] == base_s + CMD_PORT_OFS;

   always_comb begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      cmd_nxt = cmd_r;
      req_nxt = req_r;
      wdat_nxt = wdat_r;
      rdat_nxt = rdat_r;
      // four-phase request drops once the flag side acknowledged
      if (req_r && ack_q2) begin
         req_nxt = 1'b0;
      end
      if (st_r == ST_IDLE || (!lframe_n && st_r != ST_CTYP)) begin
         st_nxt = (!lframe_n && lad_in == LAD_START) ? ST_CTYP
                                                     : ST_IDLE;
      end else begin
         case (st_r)
            ST_CTYP: begin
               if (!lframe_n) begin
                  st_nxt = (lad_in == LAD_START) ? ST_CTYP : ST_IDLE;
               end else if (lad_in[3:2] == LAD_IO_TYPE) begin
                  wr_nxt = lad_in[1];
                  cnt_nxt = 2'h0;
                  st_nxt = ST_ADDR;
               end else begin
                  st_nxt = ST_IDLE;
               end
            end
            ST_ADDR: begin
               addr_nxt = {addr_r[11:0], lad_in};
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r == LAST_ADDR_NIB) begin
                  cnt_nxt = 2'h0;
                  st_nxt = wr_r ? ST_WDAT : ST_HTAR1;
               end
            end
            ST_WDAT: begin
               // low nibble first, as on the bus
               wdat_nxt = {lad_in, wdat_r[7:4]};
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r == 2'h1) begin
                  st_nxt = ST_HTAR1;
               end
            end
            ST_HTAR1: begin
               st_nxt = ST_HTAR2;
            end
            ST_HTAR2: begin
               cnt_nxt = 2'h0;
               // a miss never drives the bus; a busy handshake is
               // not expected since a cycle outlasts it by far
               if ((hit_data || hit_cmd) && !req_r && !ack_q2) begin
                  cmd_nxt = hit_cmd;
                  req_nxt = 1'b1;
                  st_nxt = ST_SWAIT;
               end else begin
                  st_nxt = ST_IDLE;
               end
            end
            ST_SWAIT: begin
               cnt_nxt = cnt_r + 2'h1;
               if (wr_r && cnt_r == WR_WAIT_SYNCS - 2'h1) begin
                  st_nxt = ST_SOK;
               end else if (!wr_r && req_r && ack_q2) begin
                  rdat_nxt = rsp_r; // stable while ack stands
                  st_nxt = ST_SOK;
               end
            end
            ST_SOK: begin
               cnt_nxt = 2'h0;
               st_nxt = wr_r ? ST_DTAR1 : ST_RDAT;
            end
            ST_RDAT: begin
               cnt_nxt = cnt_r + 2'h1;
               if (cnt_r == 2'h1) begin
                  st_nxt = ST_DTAR1;
               end
            end
            ST_DTAR1: begin
               st_nxt = ST_DTAR2;
            end
            default: begin
               st_nxt = ST_IDLE;
            end
         endcase
      end
      // registered pin drive follows the next state
      case (st_nxt)
         ST_SWAIT: begin
            oe_nxt = 1'b1;
            lad_nxt = LAD_SYNC_WAIT;
         end
         ST_SOK: begin
            oe_nxt = 1'b1;
            lad_nxt = LAD_SYNC_OK;
         end
         ST_RDAT: begin
            oe_nxt = 1'b1;
            lad_nxt = (cnt_nxt == 2'h0) ? rdat_nxt[3:0]
                                        : rdat_nxt[7:4];
         end
         ST_DTAR1: begin
            oe_nxt = 1'b1;
            lad_nxt = LAD_TAR;
         end
         default: begin
            oe_nxt = 1'b0;
            lad_nxt = 4'h0;
         end
      endcase
   end

   always_ff @(posedge lpc_clk) begin
      if (lk_rst) begin
         st_r <= ST_IDLE;
         addr_r <= 16'h0000;
         cnt_r <= 2'h0;
         wr_r <= 1'b0;
         cmd_r <= 1'b0;
         req_r <= 1'b0;
         wdat_r <= 8'h00;
         rdat_r <= 8'h00;
         lad_out <= 4'h0;
         lad_oe <= 1'b0;
      end else begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         cmd_r <= cmd_nxt;
         req_r <= req_nxt;
         wdat_r <= wdat_nxt;
         rdat_r <= rdat_nxt;
         lad_out <= lad_nxt;
         lad_oe <= oe_nxt;
      end
   end

   // ---------------- sys domain ----------------
   logic req_q1, req_q2;
   logic [7:0] flags_r, flags_nxt, rsp_nxt, rdata_nxt;
   logic ack_nxt, host_wr_ev, host_rd_ev;

   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         req_q1 <= req_r;
         req_q2 <= req_q1;
      end
   end

   // kind, port and byte are held steady by the link side under req
   assign host_wr_ev = req_q2 && !ack_r && wr_r;
   assign host_rd_ev = req_q2 && !ack_r && !wr_r;

   always_comb begin
      act_nxt = act_r;
      bhi_nxt = bhi_r;
      blo_nxt = blo_r;
      inb_nxt = inb_r;
      outb_nxt = outb_r;
      flags_nxt = flags_r;
      rsp_nxt = rsp_r;
      ack_nxt = ack_r;
      rdata_nxt = reg_rdata;
      if (host_rd_ev) begin
         rsp_nxt = cmd_r ? flags_r : outb_r;
         if (!cmd_r) begin
            flags_nxt[BIT_OBF] = 1'b0;
         end
         ack_nxt = 1'b1;
      end else if (!req_q2 && ack_r) begin
         ack_nxt = 1'b0;
      end
      if (reg_wr) begin
         if (reg_addr == IDX_ACTIVATE) begin
            act_nxt = reg_wdata[BIT_ACTIVE];
         end else if (reg_addr == IDX_BASE_HI) begin
            bhi_nxt = reg_wdata[3:0];
         end else if (reg_addr == IDX_BASE_LO) begin
            blo_nxt = reg_wdata & BASE_LO_MASK;
         end else if (reg_addr == IDX_DATA) begin
            outb_nxt = reg_wdata;
            flags_nxt[BIT_OBF] = 1'b1;
         end else if (reg_addr == IDX_FLAGS) begin
            flags_nxt = (flags_nxt & ~FLAGS_SW_MASK)
                        | (reg_wdata & FLAGS_SW_MASK);
         end
      end
      if (reg_rd) begin
         if (reg_addr == IDX_ACTIVATE) begin
            rdata_nxt = {7'h00, act_r};
         end else if (reg_addr == IDX_BASE_HI) begin
            rdata_nxt = {4'h0, bhi_r};
         end else if (reg_addr == IDX_BASE_LO) begin
            rdata_nxt = blo_r;
         end else if (reg_addr == IDX_DATA) begin
            rdata_nxt = inb_r;
            flags_nxt[BIT_IBF] = 1'b0;
         end else if (reg_addr == IDX_FLAGS) begin
            rdata_nxt = flags_r;
         end else begin
            rdata_nxt = 8'h00;
         end
      end
      // host write last so its set beats a same-cycle clear
      if (host_wr_ev) begin
         inb_nxt = wdat_r;
         flags_nxt[BIT_IBF] = 1'b1;
         flags_nxt[BIT_CMD] = cmd_r;
         ack_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         act_r <= RST_ACTIVATE;
         bhi_r <= RST_BASE_HI;
         blo_r <= RST_BASE_LO;
         inb_r <= RST_DATA;
         outb_r <= RST_DATA;
         flags_r <= RST_FLAGS;
         rsp_r <= RST_DATA;
         ack_r <= 1'b0;
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         act_r <= act_nxt;
         bhi_r <= bhi_nxt;
         blo_r <= blo_nxt;
         inb_r <= inb_nxt;
         outb_r <= outb_nxt;
         flags_r <= flags_nxt;
         rsp_r <= rsp_nxt;
         ack_r <= ack_nxt;
         reg_rdata <= rdata_nxt;
      end
   end

   // ---------------- assertions ----------------
   property p_wr_sync;
      @(posedge lpc_clk) disable iff (lk_rst)
      (st_r == ST_HTAR2 && st_nxt == ST_SWAIT && wr_r) |=>
         lad_out == LAD_SYNC_WAIT ##1 lad_out == LAD_SYNC_WAIT
         ##1 lad_out == LAD_SYNC_OK ##1 lad_out == LAD_TAR
         ##1 !lad_oe;
   endproperty
   a_wr_sync: assert property (p_wr_sync) else $error("write sync");
   property p_wait_code;
      @(posedge lpc_clk) disable iff (lk_rst)
      st_r == ST_SWAIT |-> lad_oe && lad_out == LAD_SYNC_WAIT;
   endproperty
   a_wait_code: assert property (p_wait_code) else $error("wait code");
   property p_rd_tail;
      @(posedge lpc_clk) disable iff (lk_rst || !lframe_n)
      (st_r == ST_SOK && !wr_r) |-> lad_out == LAD_SYNC_OK
         ##1 lad_out == rdat_r[3:0] ##1 lad_out == rdat_r[7:4]
         ##1 lad_out == LAD_TAR ##1 !lad_oe;
   endproperty
   a_rd_tail: assert property (p_rd_tail) else $error("read tail");
   property p_rd_end;
      @(posedge lpc_clk) disable iff (lk_rst || !lframe_n)
      st_r == ST_DTAR1 |-> lad_oe && lad_out == LAD_TAR ##1 !lad_oe;
   endproperty
   a_rd_end: assert property (p_rd_end) else $error("turnaround");
   property p_inactive;
      @(posedge lpc_clk) disable iff (lk_rst)
      (st_r == ST_HTAR2 && !cfg_q2[12]) |=> !lad_oe [*2];
   endproperty
   a_inactive: assert property (p_inactive) else $error("decoded");
   property p_bad_type;
      @(posedge lpc_clk) disable iff (lk_rst)
      (st_r == ST_CTYP && lframe_n && lad_in[3:2] != LAD_IO_TYPE)
         |=> st_r == ST_IDLE;
   endproperty
   a_bad_type: assert property (p_bad_type) else $error("cycle type");
   property p_pd_reset;
      @(posedge lpc_clk) (!pd_q2) |=> st_r == ST_IDLE && !lad_oe;
   endproperty
   a_pd_reset: assert property (p_pd_reset) else $error("power-down");
   property p_host_wr;
      @(posedge sys_clk) disable iff (reset)
      (host_wr_ev && clk_en) |=> flags_r[BIT_IBF]
         && flags_r[BIT_CMD] == $past(cmd_r) && inb_r == $past(wdat_r);
   endproperty
   a_host_wr: assert property (p_host_wr) else $error("host write");
   property p_micro_wr;
      @(posedge sys_clk) disable iff (reset)
      (reg_wr && reg_addr == IDX_DATA && clk_en) |=> flags_r[BIT_OBF];
   endproperty
   a_micro_wr: assert property (p_micro_wr) else $error("obf set");
   c_write: cover property (@(posedge lpc_clk) disable iff (lk_rst)
      st_r == ST_DTAR1 && wr_r);
   c_read: cover property (@(posedge lpc_clk) disable iff (lk_rst)
      st_r == ST_RDAT && !cmd_r);
   c_status: cover property (@(posedge sys_clk) disable iff (reset)
      host_rd_ev && cmd_r);
endmodule

// ### src/ecm_pkg.sv
// constants and types for the host mailbox over the lpc i/o link
package ecm_pkg;
   // configuration and microcontroller register indices
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_DATA = 8'h53;
   localparam logic [7:0] IDX_FLAGS = 8'h54;
   // reset values
   localparam logic RST_ACTIVATE = 1'b0;
   localparam logic [3:0] RST_BASE_HI = 4'h0;
   localparam logic [7:0] RST_BASE_LO = 8'h62;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   // field positions and masks
   localparam int BIT_ACTIVE = 0;
   localparam int BIT_OBF = 0;
   localparam int BIT_IBF = 1;
   localparam int BIT_CMD = 3;
   localparam logic [7:0] BASE_LO_MASK = 8'hfa;
   localparam logic [7:0] FLAGS_SW_MASK = 8'hf4;
   localparam logic [11:0] CMD_PORT_OFS = 12'h004;
   // link nibble codes
   localparam logic [3:0] LAD_START = 4'h0;
   localparam logic [1:0] LAD_IO_TYPE = 2'h0;
   localparam logic [3:0] LAD_SYNC_WAIT = 4'h6;
   localparam logic [3:0] LAD_SYNC_OK = 4'h0;
   localparam logic [3:0] LAD_TAR = 4'hf;
   // timing counts in link clocks
   localparam logic [1:0] WR_WAIT_SYNCS = 2'h2;
   localparam logic [1:0] LAST_ADDR_NIB = 2'h3;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_CTYP = 11'h002,
      ST_ADDR = 11'h004,
      ST_WDAT = 11'h008,
      ST_HTAR1 = 11'h010,
      ST_HTAR2 = 11'h020,
      ST_SWAIT = 11'h040,
      ST_SOK = 11'h080,
      ST_RDAT = 11'h100,
      ST_DTAR1 = 11'h200,
      ST_DTAR2 = 11'h400
   } ecm_state_e;
endpackage

// ### test/ecm_lpc_host.sv
// lpc host model issuing i/o cycles toward the mailbox
`timescale 1ns/100ps
module ecm_lpc_host (
   input wire logic lpc_clk,
   input wire logic [3:0] dev_lad,
   input wire logic dev_oe,
   output logic lframe_n,
   output logic [3:0] lad_in
);
   logic oe;
   logic [3:0] hd;
   // lines carry a pull-up, so a released bus reads 1111
   assign lad_in = dev_oe ? dev_lad : (oe ? hd : 4'hf);
   initial begin
      oe = 1'b0;
      hd = 4'hf;
      lframe_n = 1'b1;
   end
   task automatic put(input logic [3:0] v);
      @(negedge lpc_clk);
      hd = v;
   endtask
   // n wait syncs, s last sync, q read byte, t turnaround, r released
   task automatic cyc(input logic [3:0] ct, input logic [15:0] a,
      input logic [7:0] d, output int n, output logic [3:0] s,
      output logic [7:0] q, output logic [3:0] t, output logic r);
      n = 0;
      s = 4'hf;
      q = 8'h00;
      t = 4'h0;
      r = 1'b0;
      @(negedge lpc_clk);
      oe = 1'b1;
      lframe_n = 1'b0;
      hd = 4'h0;
      put(ct);
      lframe_n = 1'b1;
      for (int i = 3; i >= 0; i--) put(a[i*4+:4]);
      if (ct[1]) begin
         put(d[3:0]);
         put(d[7:4]);
      end
      put(4'hf);
      @(negedge lpc_clk);
      oe = 1'b0;
      for (int i = 0; i < 40 && dev_oe !== 1'b1; i++) @(posedge lpc_clk);
      if (dev_oe !== 1'b1) return;
      while (dev_lad === 4'h6 && n < 40) begin
         n++;
         @(posedge lpc_clk);
      end
      s = dev_lad;
      if (!ct[1]) begin
         @(posedge lpc_clk);
         q[3:0] = dev_lad;
         @(posedge lpc_clk);
         q[7:4] = dev_lad;
      end
      @(posedge lpc_clk);
      t = dev_lad;
      @(posedge lpc_clk);
      r = (dev_oe === 1'b0);
   endtask
endmodule

// ### test/ecm_host_mailbox_tb.sv
// self-checking bench for the host mailbox
`timescale 1ns/100ps
module ecm_host_mailbox_tb;
   import ecm_pkg::*;
   logic sys_clk, reset, clk_en, reg_wr, reg_rd, lpc_clk;
   logic lreset_n, lpcpd_n, lframe_n, lad_oe, r;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q, v;
   logic [3:0] lad_in, lad_out, s, t;
   logic [15:0] base;
   int fail_count = 0;
   int n_tests = 0;
   int seed = 67758;
   int n;
   logic [7:0] ra[5] = '{IDX_ACTIVATE, IDX_BASE_HI, IDX_BASE_LO, IDX_FLAGS,
      8'h77};
   logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h62, 8'h00, 8'h00};
   logic [7:0] rm[5] = '{8'h01, 8'h0f, 8'hfa, 8'hf4, 8'h00};

   ecm_host_mailbox dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lpc_clk(lpc_clk),
      .lreset_n(lreset_n), .lpcpd_n(lpcpd_n), .lframe_n(lframe_n),
      .lad_in(lad_in), .lad_out(lad_out), .lad_oe(lad_oe));
   ecm_lpc_host host (.lpc_clk(lpc_clk), .dev_lad(lad_out), .dev_oe(lad_oe),
      .lframe_n(lframe_n), .lad_in(lad_in));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // odd offset keeps the link clock unrelated to the system clock
   initial begin
      lpc_clk = 1'b0;
      #3.7;
      forever #16 lpc_clk = ~lpc_clk;
   end

   task automatic check(input string nm, input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] fexp(input logic input_full_flag, cmd, output_full_flag);
      fexp = 8'h00;
      fexp[BIT_IBF] = input_full_flag;
      fexp[BIT_CMD] = cmd;
      fexp[BIT_OBF] = output_full_flag;
   endfunction
   task automatic wr(input logic [7:0] a, d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // flags cross domains, so poll a bounded number of times
   task automatic poll(input logic [7:0] m, w, output logic [7:0] f);
      rd(IDX_FLAGS, f);
      for (int i = 0; i < 30 && (f & m) !== w; i++) rd(IDX_FLAGS, f);
   endtask
   task automatic hwrite(input logic [15:0] a, input logic [7:0] d);
      host.cyc(4'h2, a, d, n, s, q, t, r);
      check("wr_waits", 8'(n), 8'h02);
      check("wr_sync", {4'h0, s}, 8'h00);
      check("wr_tar", {4'h0, t}, 8'h0f);
      check("wr_release", {7'h0, r}, 8'h01);
   endtask
   task automatic hread(input logic [15:0] a, output logic [7:0] d);
      host.cyc(4'h0, a, 8'h00, n, s, d, t, r);
      check("rd_waits", {7'h0, n > 0}, 8'h01);
      check("rd_sync", {4'h0, s}, 8'h00);
      check("rd_tar", {4'h0, t}, 8'h0f);
      check("rd_release", {7'h0, r}, 8'h01);
   endtask
   task automatic miss(input logic [3:0] ct, input logic [15:0] a);
      host.cyc(ct, a, 8'ha5, n, s, q, t, r);
      check("miss_waits", 8'(n), 8'h00);
      check("miss_sync", {4'h0, s}, 8'h0f);
   endtask

   initial begin
      #400000;
      fail_count++;
      close_out();
   end

   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      lreset_n = 1'b0;
      lpcpd_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      lreset_n = 1'b1;
      repeat (10) @(negedge lpc_clk);
      foreach (ra[i]) begin
         rd(ra[i], q);
         check("reg_reset", q, rv[i]);
         wr(ra[i], 8'hff);
         rd(ra[i], q);
         check("reg_mask", q, rm[i]);
      end
      wr(IDX_FLAGS, 8'h00);
      // a frozen clock enable must swallow the write
      clk_en = 1'b0;
      wr(IDX_BASE_LO, 8'h00);
      clk_en = 1'b1;
      rd(IDX_BASE_LO, q);
      check("clk_en_hold", q, 8'hfa);
      $display("test registers done");
      v = 8'($random(seed));
      q = 8'($random(seed)) & BASE_LO_MASK;
      base = {4'h0, v[3:0], q};
      wr(IDX_BASE_HI, v);
      wr(IDX_BASE_LO, q);
      wr(IDX_ACTIVATE, 8'h00);
      miss(4'h2, base);
      wr(IDX_ACTIVATE, 8'h01);
      miss(4'h2, base + 16'h8);
      miss(4'h2, base + 16'h1);
      miss(4'h6, base);
      miss(4'h2, base | 16'h1000);
      $display("test decode done");
      for (int k = 0; k < 6; k++) begin
         v = (k < 2) ? {8{k[0]}} : 8'($random(seed));
         hwrite(base + (k[0] ? 16'h4 : 16'h0), v);
         poll(8'h02, 8'h02, q);
         check("flags_wr", q, fexp(1'b1, k[0], 1'b0));
         rd(IDX_DATA, q);
         check("data_in", q, v);
         rd(IDX_FLAGS, q);
         check("ibf_clear", q, fexp(1'b0, k[0], 1'b0));
      end
      $display("test host write done");
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 8'h5a : 8'($random(seed));
         wr(IDX_DATA, v);
         rd(IDX_FLAGS, q);
         check("obf_set", q, fexp(1'b0, 1'b1, 1'b1));
         hread(base + 16'h4, q);
         check("host_flags", q, fexp(1'b0, 1'b1, 1'b1));
         hread(base, q);
         check("host_data", q, v);
         poll(8'h01, 8'h00, q);
         check("obf_clear", q, fexp(1'b0, 1'b1, 1'b0));
      end
      $display("test host read done");
      wr(IDX_DATA, 8'hc3);
      @(negedge lpc_clk);
      lpcpd_n = 1'b0;
      // host stays silent for the whole power-down span
      #31000;
      check("pd_quiet", {7'h0, lad_oe}, 8'h00);
      lpcpd_n = 1'b1;
      repeat (6) @(negedge lpc_clk);
      rd(IDX_FLAGS, q);
      check("pd_flags", q, fexp(1'b0, 1'b1, 1'b1));
      v = 8'($random(seed));
      hwrite(base, v);
      poll(8'h02, 8'h02, q);
      rd(IDX_DATA, q);
      check("pd_data", q, v);
      $display("test power-down done");
      close_out();
   end
endmodule
